// file: hdl/dfs_regs.svh
// Purpose: Constants of the decimation filter and its settling control
// Assumes: 50 MHz system clock; register port with word-wide index addresses
// Notes:   Times keep their printed units; cycle counts are derived here
//
// How it works
// - Wideband path delays every input by 34 output periods, linear phase.
// - Wideband output settles 68 output periods after a ready-aligned input step.
// - A synchronization clears and restarts all filter state.
// - After sync, wideband withholds the first 68 results until settled.
// - Suppression lasts the latency for the chosen ratio and speed.
// - Latency after sync carries a fixed 0.4 us overhead at every rate.
// - Unsynchronized wideband step: results keep flowing, next 69 partially settled.
// - Enabled input buffers add eight converter clock periods of latency.
// - Low-latency mode is a CIC with sinc4, sinc4+sinc1, sinc3, sinc3+sinc1.
// - In low-latency mode the first ready after sync carries settled data.
// - Unsynchronized low-latency change settles after latency rounded up in conversions.
// - Sinc is two stages, ratio A then B; single-stage modes bypass B.
// - Modulator sample rate is half the converter clock, 12.8 or 1.6 MHz.
// - First sinc stage is order three or four, from the configuration.
// - Output word rate is modulator rate over the oversampling ratio.
// - Wideband offers eight ratios in either speed mode.
// - Sinc4+sinc1 first stage decimates by 32; stage B sets the rate.
`ifndef DFS_REGS_SVH
`define DFS_REGS_SVH

// Register indices on the register port
`define DFS_ADDR_CTRL 4'h0
`define DFS_ADDR_SYNC 4'h1
`define DFS_ADDR_STATUS 4'h2
`define DFS_ADDR_DATA 4'h3

// Control field layout and reset value
`define DFS_CTRL_W 9
`define DFS_CTRL_MODE_LSB 0
`define DFS_CTRL_OSR_LSB 3
`define DFS_CTRL_SPEED_BIT 7
`define DFS_CTRL_BUF_BIT 8
`define DFS_CTRL_RESET 9'h000
`define DFS_SYNC_BIT 0
`define DFS_STAT_RUN_BIT 0
`define DFS_STAT_NEW_BIT 1
`define DFS_STAT_WAIT_BIT 2

// Filter structure
`define DFS_WB_DELAY 34
`define DFS_WB_SETTLE (2 * `DFS_WB_DELAY)
`define DFS_WB_TAPS (`DFS_WB_SETTLE + 1)
`define DFS_WB_BASE_OSR 32
`define DFS_SINC1_A_OSR 32
`define DFS_FRAC_BITS 11

// Clock rates and latency times
`define DFS_SYS_KHZ 50000
`define DFS_HS_CLK_KHZ 25600
`define DFS_LS_CLK_KHZ 3200
`define DFS_MOD_DIV 2
`define DFS_OVH_NS 400
`define DFS_BUF_CLKS 8
`define DFS_OVH_CYC ((`DFS_OVH_NS * `DFS_SYS_KHZ + 999999) / 1000000)
`define DFS_BUF_HS_CYC ((`DFS_BUF_CLKS * `DFS_SYS_KHZ + `DFS_HS_CLK_KHZ - 1) / `DFS_HS_CLK_KHZ)
`define DFS_BUF_LS_CYC ((`DFS_BUF_CLKS * `DFS_SYS_KHZ + `DFS_LS_CLK_KHZ - 1) / `DFS_LS_CLK_KHZ)

`endif

// file: hdl/dfs_pkg.sv
// Purpose: Types and ratio decoding of the decimation filter
// Assumes: Constants come from dfs_regs.svh
// Notes:   Unknown mode codes behave as wideband
`include "dfs_regs.svh"

package dfs_pkg;

  typedef enum logic [2:0] {
    DFS_MODE_WIDEBAND = 3'h0,
    DFS_MODE_SINC4 = 3'h1,
    DFS_MODE_SINC4_SINC1 = 3'h2,
    DFS_MODE_SINC3 = 3'h3,
    DFS_MODE_SINC3_SINC1 = 3'h4
  } dfs_mode_type;

  typedef enum logic [1:0] {
    DFS_ST_WAIT = 2'h0,
    DFS_ST_SETTLE = 2'h1,
    DFS_ST_RUN = 2'h3
  } dfs_state_type;

  typedef struct packed {
    logic buf_en;
    logic low_speed;
    logic [3:0] osr_sel;
    dfs_mode_type mode;
  } dfs_cfg_type;

  // Mode decode of the sinc cascade
  function automatic logic dfs_is_casc(dfs_cfg_type c);
    return c.mode == DFS_MODE_SINC4_SINC1 || c.mode == DFS_MODE_SINC3_SINC1;
  endfunction

  function automatic logic dfs_is_wb(dfs_cfg_type c);
    return !(c.mode inside {DFS_MODE_SINC4, DFS_MODE_SINC4_SINC1, DFS_MODE_SINC3,
                            DFS_MODE_SINC3_SINC1});
  endfunction

  // Wideband front stage is a plain sum so the 69-word window alone sets settling
  function automatic logic [2:0] dfs_order(dfs_cfg_type c);
    if (dfs_is_wb(c)) begin
      return 3'h1;
    end
    return (c.mode == DFS_MODE_SINC3 || c.mode == DFS_MODE_SINC3_SINC1) ? 3'h3 : 3'h4;
  endfunction

  // First stage ratio
  function automatic logic [12:0] dfs_osr_a(dfs_cfg_type c);
    logic [3:0] s;
    s = (c.osr_sel > 4'hA) ? 4'hA : c.osr_sel;
    if (dfs_is_casc(c)) begin
      return 13'(`DFS_SINC1_A_OSR);
    end else if (dfs_is_wb(c)) begin
      return 13'(`DFS_WB_BASE_OSR) << c.osr_sel[2:0];
    end
    case (s)
      4'h0: return 13'h000C;
      4'h1: return 13'h0010;
      4'h2: return 13'h0018;
      default: return 13'h0020 << (s - 4'h3);
    endcase
  endfunction

  // Second stage ratio of the cascaded modes
  function automatic logic [9:0] dfs_osr_b(dfs_cfg_type c);
    case (c.osr_sel)
      4'h0: return 10'h002;
      4'h1: return 10'h004;
      4'h2: return 10'h00A;
      4'h3: return 10'h014;
      4'h4: return 10'h028;
      4'h5: return 10'h064;
      4'h6: return 10'h0C8;
      4'h7: return 10'h190;
      default: return 10'h3E8;
    endcase
  endfunction

  function automatic logic [3:0] dfs_clog2(logic [12:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if ((13'h0001 << i) < v) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  // Right shift that brings the full-precision sum to the output scale
  function automatic logic [6:0] dfs_shift(dfs_cfg_type c);
    logic [6:0] s;
    s = 7'(dfs_order(c)) * 7'(dfs_clog2(dfs_osr_a(c)));
    if (dfs_is_casc(c)) begin
      s = s + 7'(dfs_clog2(13'(dfs_osr_b(c))));
    end
    if (dfs_is_wb(c)) begin
      s = s + 7'(dfs_clog2(13'(`DFS_WB_TAPS)));
    end
    return s - 7'(`DFS_FRAC_BITS);
  endfunction

endpackage

// file: hdl/dfs_ring_mem.sv
// Purpose: Word store of the wideband window, one port shared by write and read
// Assumes: Read and write share one address
// Notes:   Read data come from a register and show the old word on a write
module dfs_ring_mem #(
  parameter int W = 56,
  parameter int DEPTH = 69,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [W-1:0] wr_data_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [DEPTH];

  // Registered read, write behind it
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[addr_i];
  end
endmodule // dfs_ring_mem

// file: hdl/dfs_cic.sv
// Purpose: Cascaded integrator-comb decimator of order one, three or four
// Assumes: Order and ratio only change while clear_i is high
// Notes:   Two's complement wrap in the integrators is intended
module dfs_cic #(
  parameter int IN_W = 5,
  parameter int ACC_W = 56,
  parameter int ORD_MAX = 4,
  parameter int RAT_W = 13
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  input wire logic signed [IN_W-1:0] in_data_i,
  input wire logic [2:0] order_i,
  input wire logic [RAT_W-1:0] ratio_i,
  output logic out_valid_o,
  output logic signed [ACC_W-1:0] out_data_o
);
  logic signed [ACC_W-1:0] integ [ORD_MAX];
  logic signed [ACC_W-1:0] comb_in [ORD_MAX+1];
  logic signed [ACC_W-1:0] dly [ORD_MAX];
  logic [RAT_W-1:0] dec_cnt;
  logic dump;

  // Dump once every ratio_i accepted samples
  assign dump = in_valid_i && (dec_cnt == ratio_i - RAT_W'(1));
  // Comb sees the last integrator's next value, so at order one the dumping sample counts in its own word
  assign comb_in[0] = (order_i == 3'h1) ? integ[0] + ACC_W'(in_data_i)
                    : (order_i == 3'h3) ? integ[2] + integ[1] : integ[3] + integ[2];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      dec_cnt <= '0;
    end else if (in_valid_i) begin
      dec_cnt <= dump ? '0 : dec_cnt + RAT_W'(1);
    end
  end

  // Integrator and comb sections, one per order
  genvar k;
  generate
    for (k = 0; k < ORD_MAX; k++) begin : g_sec
      if (k == 0) begin : g_first
        always_ff @(posedge clk_i) begin
          if (!reset_n_i || clear_i) begin
            integ[k] <= '0;
          end else if (in_valid_i) begin
            integ[k] <= integ[k] + ACC_W'(in_data_i);
          end
        end
      end else begin : g_next
        always_ff @(posedge clk_i) begin
          if (!reset_n_i || clear_i) begin
            integ[k] <= '0;
          end else if (in_valid_i) begin
            integ[k] <= integ[k] + integ[k-1];
          end
        end
      end
      assign comb_in[k+1] = comb_in[k] - dly[k];
      always_ff @(posedge clk_i) begin
        if (!reset_n_i || clear_i) begin
          dly[k] <= '0;
        end else if (dump) begin
          dly[k] <= comb_in[k];
        end
      end
    end
  endgenerate

  // Registered decimated output
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= dump;
      if (dump) begin
        out_data_o <= (order_i == 3'h1) ? comb_in[1]
                    : (order_i == 3'h3) ? comb_in[3] : comb_in[4];
      end
    end
  end
endmodule // dfs_cic

// file: hdl/dfs_top.sv
// Purpose: Decimation filter with restart on sync and settling suppression
// Assumes: Modulator answers mod_strobe_o with mod_valid_i one or two clocks later
// Notes:   Wideband path is a sinc1 front stage and a 69-word symmetric window
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "dfs_regs.svh"

module dfs_top #(
  parameter int MOD_W = 5,
  parameter int ACC_W = 56,
  parameter int OUT_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  output logic mod_strobe_o,
  input wire logic mod_valid_i,
  input wire logic signed [MOD_W-1:0] mod_data_i,
  output logic [OUT_W-1:0] result_word_o,
  output logic result_ready_strobe_n_o
);
  localparam int BOX_W = ACC_W + 7;
  localparam int FW = ACC_W + 10;
  localparam int PW = $clog2(`DFS_WB_TAPS);
  localparam logic [16:0] PH_WRAP = 17'(`DFS_MOD_DIV * `DFS_SYS_KHZ);
  localparam logic [7:0] OVH_CYC = 8'(`DFS_OVH_CYC);
  localparam logic [7:0] BUF_HS_CYC = 8'(`DFS_BUF_HS_CYC);
  localparam logic [7:0] BUF_LS_CYC = 8'(`DFS_BUF_LS_CYC);
  localparam logic [PW-1:0] LAST_PTR = PW'(`DFS_WB_TAPS - 1);
  localparam logic [PW-1:0] FULL = PW'(`DFS_WB_TAPS);

  dfs_pkg::dfs_cfg_type ctrl;
  dfs_pkg::dfs_cfg_type cfg;
  dfs_pkg::dfs_state_type state;
  logic sync_req;
  logic wb;
  logic casc;
  logic [16:0] phase;
  logic [16:0] next_phase;
  logic [7:0] wait_tmr;
  logic [6:0] drop_cnt;
  logic stage_ev;
  logic a_valid;
  logic signed [ACC_W-1:0] a_data;
  logic [12:0] a_ratio;
  logic [9:0] b_ratio;
  logic box_ev;
  logic box_v;
  logic [PW-1:0] box_ptr;
  logic [PW-1:0] box_fill;
  logic signed [ACC_W-1:0] box_old;
  logic signed [BOX_W-1:0] box_sum;
  logic [9:0] b_cnt;
  logic signed [FW-1:0] b_acc;
  logic signed [FW-1:0] b_out;
  logic b_v;
  logic fin_v;
  logic signed [FW-1:0] fin_val;
  logic new_data;

  assign sync_req = bus_wr_i && bus_addr_i == `DFS_ADDR_SYNC && bus_wdata_i[`DFS_SYNC_BIT];
  assign wb = dfs_pkg::dfs_is_wb(cfg);
  assign casc = dfs_pkg::dfs_is_casc(cfg);
  assign a_ratio = dfs_pkg::dfs_osr_a(cfg);
  assign b_ratio = dfs_pkg::dfs_osr_b(cfg);

  // Staged configuration written by software
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl <= dfs_pkg::dfs_cfg_type'(`DFS_CTRL_RESET);
    end else if (bus_wr_i && bus_addr_i == `DFS_ADDR_CTRL) begin
      ctrl <= dfs_pkg::dfs_cfg_type'(bus_wdata_i[`DFS_CTRL_W-1:0]);
    end
  end

  // Active configuration, taken over only at sync
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg <= dfs_pkg::dfs_cfg_type'(`DFS_CTRL_RESET);
    end else if (sync_req) begin
      cfg <= ctrl;
    end
  end

  // Modulator tick: converter clock over two, by phase accumulation
  assign next_phase = phase + (cfg.low_speed ? 17'(`DFS_LS_CLK_KHZ) : 17'(`DFS_HS_CLK_KHZ));
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase <= '0;
      mod_strobe_o <= 1'b0;
    end else if (next_phase >= PH_WRAP) begin
      phase <= next_phase - PH_WRAP;
      mod_strobe_o <= 1'b1;
    end else begin
      phase <= next_phase;
      mod_strobe_o <= 1'b0;
    end
  end

  // Which stage output counts toward settling
  assign stage_ev = wb ? box_v : a_valid;

  // Restart, overhead wait and suppression sequence
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= dfs_pkg::DFS_ST_WAIT;
      wait_tmr <= OVH_CYC;
      drop_cnt <= '0;
    end else if (sync_req) begin
      state <= dfs_pkg::DFS_ST_WAIT;
      wait_tmr <= OVH_CYC + (ctrl.buf_en ? (ctrl.low_speed ? BUF_LS_CYC : BUF_HS_CYC)
                                         : 8'h00);
    end else begin
      case (state)
        dfs_pkg::DFS_ST_WAIT: begin
          if (wait_tmr == 8'h00) begin
            state <= dfs_pkg::DFS_ST_SETTLE;
            drop_cnt <= wb ? 7'(`DFS_WB_SETTLE) : 7'(dfs_pkg::dfs_order(cfg) - 3'h1);
          end else begin
            wait_tmr <= wait_tmr - 8'h01;
          end
        end
        dfs_pkg::DFS_ST_SETTLE: begin
          if (stage_ev) begin
            drop_cnt <= drop_cnt - 7'h01;
            if (drop_cnt == 7'h01) begin
              state <= dfs_pkg::DFS_ST_RUN;
            end
          end
        end
        dfs_pkg::DFS_ST_RUN: begin
          state <= dfs_pkg::DFS_ST_RUN;
        end
        default: begin
          state <= dfs_pkg::DFS_ST_WAIT;
        end
      endcase
    end
  end

  // First decimation stage, held clear during the restart wait
  dfs_cic #(
    .IN_W(MOD_W),
    .ACC_W(ACC_W),
    .ORD_MAX(4),
    .RAT_W(13)
  ) u_cic (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(state == dfs_pkg::DFS_ST_WAIT),
    .in_valid_i(mod_valid_i && state != dfs_pkg::DFS_ST_WAIT),
    .in_data_i(mod_data_i),
    .order_i(dfs_pkg::dfs_order(cfg)),
    .ratio_i(a_ratio),
    .out_valid_o(a_valid),
    .out_data_o(a_data)
  );

  // Wideband symmetric window over the last 69 stage words
  assign box_ev = a_valid && wb;
  dfs_ring_mem #(
    .W(ACC_W),
    .DEPTH(`DFS_WB_TAPS),
    .AW(PW)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(box_ev),
    .addr_i(box_ptr),
    .wr_data_i(a_data),
    .rd_data_o(box_old)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state == dfs_pkg::DFS_ST_WAIT) begin
      box_ptr <= '0;
      box_fill <= '0;
      box_sum <= '0;
      box_v <= 1'b0;
    end else begin
      box_v <= box_ev;
      if (box_ev) begin
        box_ptr <= (box_ptr == LAST_PTR) ? '0 : box_ptr + PW'(1);
        box_fill <= (box_fill == FULL) ? FULL : box_fill + PW'(1);
        box_sum <= box_sum + BOX_W'(a_data)
                   - ((box_fill == FULL) ? BOX_W'(box_old) : '0);
      end
    end
  end

  // Second stage: plain sum over b_ratio settled first-stage words
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state != dfs_pkg::DFS_ST_RUN) begin
      b_cnt <= '0;
      b_acc <= '0;
      b_out <= '0;
      b_v <= 1'b0;
    end else begin
      b_v <= 1'b0;
      if (a_valid && casc) begin
        if (b_cnt == b_ratio - 10'h001) begin
          b_out <= b_acc + FW'(a_data);
          b_acc <= '0;
          b_cnt <= '0;
          b_v <= 1'b1;
        end else begin
          b_acc <= b_acc + FW'(a_data);
          b_cnt <= b_cnt + 10'h001;
        end
      end
    end
  end

  // Final word selection; nothing leaves before settling ends
  always_comb begin
    fin_v = 1'b0;
    fin_val = '0;
    if (state == dfs_pkg::DFS_ST_RUN) begin
      if (wb) begin
        fin_v = box_v;
        fin_val = FW'(box_sum);
      end else if (casc) begin
        fin_v = b_v;
        fin_val = b_out;
      end else begin
        fin_v = a_valid;
        fin_val = FW'(a_data);
      end
    end
  end

  // Result word and active-low ready strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      result_word_o <= '0;
      result_ready_strobe_n_o <= 1'b1;
    end else begin
      result_ready_strobe_n_o <= !fin_v;
      if (fin_v) begin
        result_word_o <= OUT_W'(fin_val >>> dfs_pkg::dfs_shift(cfg));
      end
    end
  end

  // New-data flag: a new word wins over the clearing read
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      new_data <= 1'b0;
    end else if (fin_v) begin
      new_data <= 1'b1;
    end else if (bus_rd_i && bus_addr_i == `DFS_ADDR_DATA) begin
      new_data <= 1'b0;
    end
  end

  // Register reads, answered in the next cycle only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !bus_rd_i) begin
      bus_rdata_o <= '0;
    end else begin
      case (bus_addr_i)
        `DFS_ADDR_CTRL: bus_rdata_o <= {{(32 - `DFS_CTRL_W){1'b0}}, ctrl};
        `DFS_ADDR_STATUS: begin
          bus_rdata_o <= '0;
          bus_rdata_o[`DFS_STAT_RUN_BIT] <= state == dfs_pkg::DFS_ST_RUN;
          bus_rdata_o[`DFS_STAT_NEW_BIT] <= new_data;
          bus_rdata_o[`DFS_STAT_WAIT_BIT] <= state == dfs_pkg::DFS_ST_WAIT;
        end
        `DFS_ADDR_DATA: bus_rdata_o <= 32'(signed'(result_word_o));
        default: bus_rdata_o <= '0;
      endcase
    end
  end

  // Checks
  logic [8:0] wait_cyc;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || sync_req || state != dfs_pkg::DFS_ST_WAIT) begin
      wait_cyc <= '0;
    end else begin
      wait_cyc <= wait_cyc + 9'h001;
    end
  end

  default clocking dfs_cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_sync_restart: assert property (sync_req |=> state == dfs_pkg::DFS_ST_WAIT ##1
      (!a_valid && box_fill == '0))
    else $error("sync did not restart filter");
  a_overhead_time: assert property ($past(state) == dfs_pkg::DFS_ST_WAIT && !$past(sync_req)
      && state == dfs_pkg::DFS_ST_SETTLE && !cfg.buf_en
      |-> wait_cyc == 9'(`DFS_OVH_CYC) + 9'h001)
    else $error("overhead wait length wrong");
  a_buffer_time: assert property ($past(state) == dfs_pkg::DFS_ST_WAIT && !$past(sync_req)
      && state == dfs_pkg::DFS_ST_SETTLE && cfg.buf_en
      |-> wait_cyc == 9'(`DFS_OVH_CYC) + 9'h001 + (cfg.low_speed ? 9'(`DFS_BUF_LS_CYC)
                                                       : 9'(`DFS_BUF_HS_CYC)))
    else $error("buffer latency not added");
  a_wb_withheld: assert property (fin_v && wb |-> box_fill == FULL)
    else $error("wideband word released early");
  a_ready_settled: assert property ($fell(result_ready_strobe_n_o)
      |-> $past(state) == dfs_pkg::DFS_ST_RUN)
    else $error("ready before settling");
  a_ready_pulse: assert property ($fell(result_ready_strobe_n_o) |=> result_ready_strobe_n_o)
    else $error("ready strobe longer than one cycle");
  a_casc_ratio: assert property (casc |-> a_ratio == 13'h0020)
    else $error("cascade first stage not 32");
  a_wb_ratio: assert property (wb |-> $onehot(a_ratio) && a_ratio >= 13'h0020)
    else $error("wideband ratio out of set");
  a_cfg_hold: assert property (!sync_req |=> $stable(cfg))
    else $error("configuration changed without sync");
  a_mod_rate: assert property (mod_strobe_o |=> !mod_strobe_o)
    else $error("modulator tick above half clock");

  c_wb_word: cover property (wb && !result_ready_strobe_n_o);
  c_casc_word: cover property (casc && !result_ready_strobe_n_o);
  c_sync_in_run: cover property (state == dfs_pkg::DFS_ST_RUN && sync_req);
  c_buf_wait: cover property (cfg.buf_en && state == dfs_pkg::DFS_ST_SETTLE);
endmodule // dfs_top

// file: dv/dfs_mod_model.sv
// Purpose: Modulator stand-in that answers each sample request
// Assumes: Requests are one-cycle pulses, never two in a row
// Notes: Data line shows the inverse of its last value while not valid
module dfs_mod_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic mod_strobe_i,
  input wire logic slow_i,
  input wire logic signed [4:0] level_i,
  output logic mod_valid_o,
  output logic signed [4:0] mod_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pend;
  logic fire;
  // Prompt answer one cycle after the request, slow answer one cycle later still
  assign fire = slow_i ? pend : mod_strobe_i;
  // Sample delivery
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend <= 1'b0;
      mod_valid_o <= 1'b0;
      mod_data_o <= 5'h00;
    end else begin
      pend <= mod_strobe_i;
      mod_valid_o <= fire;
      mod_data_o <= fire ? level_i : ~mod_data_o;
    end
  end
endmodule // dfs_mod_model

// file: dv/test_decimation_filter_settling.sv
// Purpose: Self-checking bench of the decimation filter
// Assumes: 50 MHz clock, modulator model on the sample link
// Notes: Constant random levels give exact settled words
`include "dfs_regs.svh"
module test_decimation_filter_settling;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_n_i, bus_wr_i, bus_rd_i, slow, mod_strobe_o, mod_valid_i, strobe_n;
  logic [3:0] bus_addr_i;
  logic [31:0] bus_wdata_i, bus_rdata_o, v, seed;
  logic signed [4:0] mod_data_i, lvl;
  logic [23:0] word, keep, word_w;
  int mismatches, n_compared, cyc, t0, t1, tb, ts, c;
  logic [8:0] cfg [4] = '{9'h019, 9'h01B, 9'h002, 9'h004};
  int nw [4] = '{4, 3, 5, 4};

  dfs_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .mod_strobe_o(mod_strobe_o), .mod_valid_i(mod_valid_i),
    .mod_data_i(mod_data_i), .result_word_o(word_w), .result_ready_strobe_n_o(strobe_n));
  dfs_mod_model u_mod (.clk_i(clk_i), .reset_n_i(reset_n_i), .mod_strobe_i(mod_strobe_o),
    .slow_i(slow), .level_i(lvl), .mod_valid_o(mod_valid_i), .mod_data_o(mod_data_i));

  // Clock and cycle count
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Value and range comparisons
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Random level, never zero
  function automatic logic signed [4:0] rnd_lvl();
    int r;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    r = int'(seed % 32'd15) + 1;
    return seed[8] ? 5'(-r) : 5'(r);
  endfunction
  // Settled word: wideband 32*69 >>> 1, sinc modes 2^11 per level step
  function automatic logic [23:0] exp_val(logic [2:0] m, logic signed [4:0] d);
    return (m == 3'h0) ? 24'(int'(d) * 1104) : 24'(int'(d) * 2048);
  endfunction

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_wr_i <= 1'b1;
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1 v = bus_rdata_o;
  endtask

  // Bounded wait for the next result strobe
  task automatic wait_word();
    for (int i = 0; i < 9500; i++) begin
      @(posedge clk_i);
      #1;
      if (strobe_n === 1'b0) begin
        word = word_w;
        t1 = cyc;
        return;
      end
    end
    mismatches++;
    print_verdict();
  endtask
  task automatic count_mod();
    c = 0;
    repeat (1000) begin
      @(posedge clk_i);
      #1;
      if (mod_strobe_o === 1'b1) c++;
    end
  endtask

  // Configure, synchronize and check the first delivered word
  task automatic run(input logic [8:0] cf, input int n, input int p);
    lvl <= rnd_lvl();
    wr(`DFS_ADDR_CTRL, 32'(cf));
    wr(`DFS_ADDR_SYNC, 32'h0000_0001);
    t0 = cyc;
    rd(`DFS_ADDR_STATUS);
    chk("restart wait", 32'h0000_0001, 32'(v[2]));
    wait_word();
    chk_rng("first word time", (n - 1) * p, (n + 1) * p + 60, t1 - t0);
    chk("first word", 32'(exp_val(cf[2:0], lvl)), 32'(word));
  endtask

  // Main sequence
  initial begin
    seed = 32'h8c64_dd71;
    reset_n_i = 1'b0;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    bus_addr_i = 4'h0;
    bus_wdata_i = 32'h0000_0000;
    slow = 1'b0;
    lvl = 5'h00;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(`DFS_ADDR_CTRL);
    chk("ctrl reset", 32'h0000_0000, v);
    rd(4'h9);
    chk("unmapped read", 32'h0000_0000, v);
    count_mod();
    chk_rng("strobes hs", 255, 257, c);
    run(9'h000, 69, 125);
    rd(`DFS_ADDR_STATUS);
    chk("new data set", 32'h0000_0001, 32'(v[1]));
    rd(`DFS_ADDR_DATA);
    chk("data reg", {{8{word[23]}}, word}, v);
    rd(`DFS_ADDR_STATUS);
    chk("new data clear", 32'h0000_0000, 32'(v[1]));
    tb = t1;
    keep = word;
    wr(`DFS_ADDR_CTRL, 32'h0000_0019);
    wait_word();
    chk_rng("word spacing", 125, 125, t1 - tb);
    chk("config held", 32'(keep), 32'(word));
    lvl <= ~lvl;
    tb = t1;
    repeat (70) wait_word();
    chk_rng("words after step", 8748, 8752, t1 - tb);
    chk("settled after step", 32'(exp_val(3'h0, lvl)), 32'(word));
    for (int i = 0; i < 4; i++) begin
      slow <= (i > 1);
      run(cfg[i], nw[i], 125);
      if (i == 0) ts = t1 - t0;
      if (i > 1) begin
        tb = t1;
        wait_word();
        chk_rng("cascade spacing", 250, 250, t1 - tb);
      end
    end
    run(9'h119, 4, 125);
    chk_rng("buffer latency", 8, 24, t1 - t0 - ts);
    run(9'h099, 4, 1000);
    count_mod();
    chk_rng("strobes ls", 31, 33, c);
    print_verdict();
  end
endmodule // test_decimation_filter_settling
